// *** design/txod_decode.sv ***
// Transmit offload block decoder: offsets, tag insert, scheduled send, large send.
// Assumes one block presented per load pulse and a frame path that answers seg_done.
//
// Overview of operation
// - Transport offset used unless hardware parses
// - Network offset used unless hardware parses
// - Offset excludes tag only when device inserts
// - Insert type 8100 then 16-bit tag
// - Mode bit 1 of byte 13 enables tag
// - Bit 4 of byte 13 selects scheduled release
// - Bit 0 clear: use supplied offsets, count
// - Bit 7 of byte 12 selects large send
// - Large send splits into separate frames
// - Full-size segments except remainder at end
// - Hold until scheduling counter reaches stamp
// - Parameters of a clear mode are ignored
`timescale 1ns/1ps
`default_nettype none
module txod_decode
   import txod_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        blk_load,
   input  wire logic [7:0]  mode_lo,
   input  wire logic [7:0]  mode_hi,
   input  wire logic [15:0] segment_payload_limit,
   input  wire logic [19:0] sched_value,
   input  wire logic [15:0] tag_field,
   input  wire logic [7:0]  network_header_offset,
   input  wire logic [7:0]  transport_header_offset,
   input  wire logic [15:0] total_payload,
   input  wire logic [16:0] sched_counter,
   input  wire logic        seg_done,
   output logic             busy,
   output logic             seg_start,
   output logic [15:0]      seg_len,
   output logic             seg_last,
   output logic [15:0]      seg_index,
   output logic             tag_insert_bit,
   output logic [31:0]      tag_insert_word,
   output logic             use_sw_offsets,
   output logic [7:0]       net_ofs_out,
   output logic [7:0]       xport_ofs_out,
   output logic [15:0]      payload_count,
   output logic             hdr_rebuild,
   output logic [2:0]       sched_window,
   output logic             rsv_violation
);
   typedef enum logic [3:0]
   {
      TXOD_IDLE  = 4'b0001,
      TXOD_WAIT  = 4'b0010,
      TXOD_SEND  = 4'b0100,
      TXOD_FRAME = 4'b1000
   } txod_state_t;

   typedef struct packed
   {
      txod_state_t st;
      logic        lsend;
      logic        sched;
      logic        hwp;
      logic        tagen;
      logic [15:0] tag;
      logic [7:0]  nofs;
      logic [7:0]  tofs;
      logic [15:0] limit;
      logic [15:0] remain;
      logic [15:0] total;
      logic [16:0] stamp;
      logic [2:0]  win;
      logic [15:0] len;
      logic        last;
      logic [15:0] idx;
      logic        start;
      logic        rsv;
   } txod_regs_t;

   txod_regs_t  st_ff;
   txod_regs_t  nxt_st;
   logic [15:0] calc_len;
   logic        calc_last;

   txod_seg_calc txod_seg_calc_i
   (
      .remain   (st_ff.remain),
      .limit    (st_ff.limit),
      .seg_len  (calc_len),
      .last_seg (calc_last)
   );

   function automatic logic mode_bit(input logic [7:0] b, input int pos);
      mode_bit = b[pos];
   endfunction

   always_comb
   begin
      nxt_st       = st_ff;
      nxt_st.start = 1'b0;
      unique case (st_ff.st)
         TXOD_IDLE:
         begin
            if (blk_load)
            begin
               nxt_st.lsend = mode_bit(mode_lo, TXOD_BIT_LARGE_SEND);
               nxt_st.sched = mode_bit(mode_hi, TXOD_BIT_SCHED);
               nxt_st.hwp   = mode_bit(mode_hi, TXOD_BIT_HW_PARSE);
               nxt_st.tagen = mode_bit(mode_hi, TXOD_BIT_TAG_INSERT);
               nxt_st.rsv   = |mode_hi[TXOD_RSV_HI:TXOD_RSV_LO];
               // Clear mode discards its parameters
               nxt_st.tag   = nxt_st.tagen ? tag_field : TXOD_ZERO16;
               nxt_st.nofs  = nxt_st.hwp ? 8'h00 : network_header_offset;
               nxt_st.tofs  = nxt_st.hwp ? 8'h00 : transport_header_offset;
               nxt_st.limit = nxt_st.lsend ? segment_payload_limit : TXOD_ZERO16;
               nxt_st.total = (nxt_st.lsend || !nxt_st.hwp) ? total_payload : TXOD_ZERO16;
               nxt_st.remain = nxt_st.lsend ? total_payload : TXOD_ZERO16;
               nxt_st.stamp = nxt_st.sched ? sched_value[TXOD_STAMP_W-1:0] : TXOD_ZERO17;
               nxt_st.win   = nxt_st.sched ? sched_value[TXOD_STAMP_W+TXOD_WIN_W-1:TXOD_STAMP_W]
                                           : 3'h0;
               nxt_st.idx   = TXOD_ZERO16;
               nxt_st.st    = nxt_st.sched ? TXOD_WAIT : TXOD_SEND;
            end
         end
         TXOD_WAIT:
         begin
            if (sched_counter == st_ff.stamp)
               nxt_st.st = TXOD_SEND;
         end
         TXOD_SEND:
         begin
            nxt_st.start = 1'b1;
            if (st_ff.lsend)
            begin
               nxt_st.len    = calc_len;
               nxt_st.last   = calc_last;
               nxt_st.remain = st_ff.remain - calc_len;
            end
            else
            begin
               nxt_st.len  = st_ff.total;
               nxt_st.last = 1'b1;
            end
            nxt_st.st = TXOD_FRAME;
         end
         TXOD_FRAME:
         begin
            if (seg_done)
            begin
               if (st_ff.last)
                  nxt_st.st = TXOD_IDLE;
               else
               begin
                  nxt_st.idx = st_ff.idx + 16'h0001;
                  nxt_st.st  = TXOD_SEND;
               end
            end
         end
         default:
            nxt_st.st = TXOD_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (sys_rst)
         st_ff <= '{st: TXOD_IDLE, default: '0};
      else
         st_ff <= nxt_st;
   end

   assign busy            = (st_ff.st != TXOD_IDLE);
   assign seg_start       = st_ff.start;
   assign seg_len         = st_ff.len;
   assign seg_last        = st_ff.last;
   assign seg_index       = st_ff.idx;
   assign tag_insert_bit  = st_ff.tagen;
   assign tag_insert_word = st_ff.tagen ? {TXOD_TAG_TYPE, st_ff.tag} : '0;
   assign use_sw_offsets  = ~st_ff.hwp;
   // Memory-side offset already counts a stored tag; inserted one is not added
   assign net_ofs_out     = st_ff.nofs;
   assign xport_ofs_out   = st_ff.tofs;
   assign payload_count   = st_ff.total;
   assign hdr_rebuild     = st_ff.lsend;
   assign sched_window    = st_ff.win;
   assign rsv_violation   = st_ff.rsv;

   property p_sched_hold;
      @(posedge mclk) disable iff (sys_rst)
      (st_ff.st == TXOD_WAIT && sched_counter != st_ff.stamp)
      |=> (st_ff.st == TXOD_WAIT && !seg_start);
   endproperty
   a_sched_hold: assert property (p_sched_hold) else $error("early scheduled send");

   property p_sched_release;
      @(posedge mclk) disable iff (sys_rst)
      (st_ff.st == TXOD_WAIT && sched_counter == st_ff.stamp) |=> ##1 seg_start;
   endproperty
   a_sched_release: assert property (p_sched_release) else $error("no release");

   property p_seg_size;
      @(posedge mclk) disable iff (sys_rst)
      (seg_start && hdr_rebuild && !seg_last) |-> seg_len == st_ff.limit;
   endproperty
   a_seg_size: assert property (p_seg_size) else $error("bad segment size");

   property p_seg_next;
      @(posedge mclk) disable iff (sys_rst)
      (st_ff.st == TXOD_FRAME && seg_done && !seg_last)
      |=> ##1 (seg_start && seg_index == $past(seg_index, 2) + 16'h0001);
   endproperty
   a_seg_next: assert property (p_seg_next) else $error("segment not split");

   property p_tag_word;
      @(posedge mclk) disable iff (sys_rst)
      tag_insert_bit |-> tag_insert_word[TXOD_INS_W-1:16] == TXOD_TAG_TYPE;
   endproperty
   a_tag_word: assert property (p_tag_word) else $error("bad tag type");

   property p_no_tag;
      @(posedge mclk) disable iff (sys_rst)
      !tag_insert_bit |-> tag_insert_word == '0;
   endproperty
   a_no_tag: assert property (p_no_tag) else $error("tag without enable");

   property p_hw_ofs;
      @(posedge mclk) disable iff (sys_rst)
      !use_sw_offsets |-> (net_ofs_out == 8'h00 && xport_ofs_out == 8'h00);
   endproperty
   a_hw_ofs: assert property (p_hw_ofs) else $error("offsets not ignored");

   property p_sw_ofs;
      @(posedge mclk) disable iff (sys_rst)
      (st_ff.st == TXOD_IDLE && blk_load && !mode_hi[TXOD_BIT_HW_PARSE])
      |=> net_ofs_out == $past(network_header_offset)
          && xport_ofs_out == $past(transport_header_offset);
   endproperty
   a_sw_ofs: assert property (p_sw_ofs) else $error("offset not taken");

   property p_mode_ignore;
      @(posedge mclk) disable iff (sys_rst)
      (st_ff.st == TXOD_IDLE && blk_load && !mode_lo[TXOD_BIT_LARGE_SEND])
      |=> st_ff.limit == TXOD_ZERO16 && !hdr_rebuild;
   endproperty
   a_mode_ignore: assert property (p_mode_ignore) else $error("limit kept");
endmodule
`default_nettype wire

// *** design/txod_pkg.sv ***
// Package for the transmit offload block decoder.
// Assumes the block words arrive already fetched, byte offsets as in memory.
package txod_pkg;
   // Byte positions inside the block
   localparam logic [7:0] TXOD_OFS_SEG_LIMIT  = 8'h0e;
   localparam logic [7:0] TXOD_OFS_ACT_LO     = 8'h10;
   localparam logic [7:0] TXOD_OFS_MODE_LO    = 8'h12;
   localparam logic [7:0] TXOD_OFS_MODE_HI    = 8'h13;
   localparam logic [7:0] TXOD_OFS_TAG        = 8'h14;
   localparam logic [7:0] TXOD_OFS_NET_OFS    = 8'h16;
   localparam logic [7:0] TXOD_OFS_XPORT_OFS  = 8'h17;
   localparam logic [7:0] TXOD_OFS_TOTAL_PAY  = 8'h1e;
   // Mode byte bit positions
   localparam int TXOD_BIT_HW_PARSE   = 0;
   localparam int TXOD_BIT_TAG_INSERT = 1;
   localparam int TXOD_BIT_SCHED      = 4;
   localparam int TXOD_BIT_LARGE_SEND = 7;
   localparam int TXOD_RSV_HI         = 7;
   localparam int TXOD_RSV_LO         = 5;
   // Schedule field layout
   localparam int TXOD_STAMP_W        = 17;
   localparam int TXOD_WIN_W          = 3;
   // Tag insertion
   localparam logic [15:0] TXOD_TAG_TYPE  = 16'h8100;
   localparam logic [7:0]  TXOD_TAG_BYTES = 8'h04;
   localparam int TXOD_INS_W          = 32;
   // Zero and one constants
   localparam logic [15:0] TXOD_ZERO16    = 16'h0000;
   localparam logic [16:0] TXOD_ZERO17    = 17'h00000;
   localparam logic [16:0] TXOD_ONE17     = 17'h00001;
endpackage

// *** design/txod_seg_calc.sv ***
// Segment length calculator for large send.
// Assumes limit is nonzero when large send is active.
`timescale 1ns/1ps
`default_nettype none
module txod_seg_calc
(
   input  wire logic [15:0] remain,
   input  wire logic [15:0] limit,
   output logic      [15:0] seg_len,
   output logic             last_seg
);
   always_comb
   begin
      if (remain <= limit)
      begin
         seg_len  = remain;
         last_seg = 1'b1;
      end
      else
      begin
         seg_len  = limit;
         last_seg = 1'b0;
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_txod_decode.sv ***
// Testbench for the transmit offload block decoder.
// Assumes the path model answers frames; bench plays the block writer.
`timescale 1ns/1ps
`default_nettype none
module tb_txod_decode;
   import txod_pkg::*;
   logic        mclk = 1'b0, sys_rst = 1'b1, blk_load = 1'b0, slow = 1'b0;
   logic [7:0]  lo = 8'h00, hi = 8'h00, net = 8'h00, xp = 8'h00, net_o, xp_o;
   logic [15:0] lim = 16'h0000, tag = 16'h0000, tot = 16'h0000, len, idx, pay;
   logic [19:0] sv = 20'h00000;
   logic [16:0] cnt = 17'h00000;
   logic        seg_done, busy, st, last, tib, sw, reb, rsv;
   logic [31:0] tword;
   logic [2:0]  win;
   int          failures = 0, checked = 0;
   always #12.5 mclk = ~mclk;
   always @(posedge mclk) cnt <= cnt + 17'h00001;
   txod_decode txod_decode_i (.mclk(mclk), .sys_rst(sys_rst), .blk_load(blk_load),
      .mode_lo(lo), .mode_hi(hi), .segment_payload_limit(lim), .sched_value(sv),
      .tag_field(tag), .network_header_offset(net), .transport_header_offset(xp),
      .total_payload(tot), .sched_counter(cnt), .seg_done(seg_done), .busy(busy),
      .seg_start(st), .seg_len(len), .seg_last(last), .seg_index(idx),
      .tag_insert_bit(tib), .tag_insert_word(tword), .use_sw_offsets(sw),
      .net_ofs_out(net_o), .xport_ofs_out(xp_o), .payload_count(pay),
      .hdr_rebuild(reb), .sched_window(win), .rsv_violation(rsv));
   txod_path_model txod_path_model_i (.mclk(mclk), .sys_rst(sys_rst), .seg_start(st),
      .slow(slow), .seg_done(seg_done));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic load(input logic [7:0] l, h, input logic [15:0] m, t, input logic [19:0] s);
      tick(1);
      lo = l;
      hi = h;
      lim = m;
      tot = t;
      sv = s;
      blk_load = 1'b1;
      tick(1);
      blk_load = 1'b0;
      tick(1);
   endtask
   task automatic wait_start(input int lim_n);
      int n;
      n = 0;
      while (st !== 1'b1 && n < lim_n)
      begin
         tick(1);
         n++;
      end
      chk("seg_start", 1, st);
   endtask
   task automatic frames(input logic [15:0] t, m, input logic ls);
      logic [15:0] left, e;
      int i, n;
      left = t;
      i = 0;
      do
      begin
         e = (ls && left > m) ? m : left;
         wait_start(40);
         chk("seg_len", e, len);
         chk("seg_last", left == e, last);
         chk("seg_index", i, idx);
         left = left - e;
         i++;
         tick(1);
         chk("seg_start", 0, st);
      end while (left != 16'h0000 && i < 10);
      n = 0;
      while (busy !== 1'b0 && n < 40)
      begin
         tick(1);
         n++;
      end
      chk("busy", 0, busy);
   endtask
   task automatic t_soft();
      net = 8'h0e;
      xp = 8'h22;
      tag = 16'habcd;
      load(8'h00, 8'h00, 16'h0010, 16'h05dc, 20'hfffff);
      chk("sw", 1, sw);
      chk("net_ofs", 8'h0e, net_o);
      chk("xport_ofs", 8'h22, xp_o);
      chk("tag_bit", 0, tib);
      chk("tag_word", 0, tword);
      chk("window", 0, win);
      chk("rebuild", 0, reb);
      chk("payload", 16'h05dc, pay);
      chk("rsv", 0, rsv);
      frames(16'h05dc, 16'h0010, 1'b0);
   endtask
   task automatic t_hw_tag();
      tag = 16'h6123;
      // Reserved bits set on purpose to exercise the flag
      load(8'h00, 8'he3, 16'h0000, 16'h0100, 20'h00000);
      chk("sw", 0, sw);
      chk("net_ofs", 0, net_o);
      chk("xport_ofs", 0, xp_o);
      chk("tag_bit", 1, tib);
      chk("tag_word", {TXOD_TAG_TYPE, 16'h6123}, tword);
      chk("payload", 0, pay);
      chk("rsv", 1, rsv);
      wait_start(40);
      tick(40);
      chk("busy", 0, busy);
   endtask
   task automatic t_large();
      slow = 1'b1;
      load(8'h80, 8'h00, 16'h012c, 16'h03e8, 20'h00000);
      chk("rebuild", 1, reb);
      chk("payload", 16'h03e8, pay);
      frames(16'h03e8, 16'h012c, 1'b1);
      slow = 1'b0;
      load(8'h80, 8'h00, 16'h012c, 16'h0258, 20'h00000);
      frames(16'h0258, 16'h012c, 1'b1);
   endtask
   task automatic t_sched();
      logic [16:0] stamp;
      stamp = cnt + 17'h00040;
      load(8'h00, 8'h10, 16'h0000, 16'h0040, {3'h5, stamp});
      chk("window", 3'h5, win);
      // Load while waiting must be ignored
      net = 8'h55;
      blk_load = 1'b1;
      tick(1);
      blk_load = 1'b0;
      chk("net_ofs", 8'h0e, net_o);
      wait_start(120);
      chk("sched_delay", stamp + 17'h00002, cnt);
      frames(16'h0040, 16'h0000, 1'b0);
   endtask
   task automatic report_and_stop();
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      tick(10);
      sys_rst = 1'b0;
      chk("busy", 0, busy);
      t_soft();
      t_hw_tag();
      t_large();
      t_sched();
      report_and_stop();
   end
   initial
   begin
      #(25 * 3000);
      failures++;
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** tb/txod_path_model.sv ***
// Frame path stand-in: answers each frame start with a one-cycle done.
// Assumes seg_start is a one-cycle pulse on mclk; slow stretches the wait.
`timescale 1ns/1ps
`default_nettype none
module txod_path_model
(
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic seg_start,
   input  wire logic slow,
   output logic      seg_done
);
   logic [3:0] wait_ff;
   always_ff @(posedge mclk)
   begin
      seg_done <= 1'b0;
      if (sys_rst)
         wait_ff <= 4'h0;
      else if (seg_start)
         wait_ff <= slow ? 4'h8 : 4'h1;
      else if (wait_ff != 4'h0)
      begin
         wait_ff  <= wait_ff - 4'h1;
         seg_done <= (wait_ff == 4'h1);
      end
   end
endmodule
`default_nettype wire
